// *** inc/frm_defines.vh ***
// register map, field positions, reset values and timing of the fault response manager
`ifndef FRM_DEFINES_VH
`define FRM_DEFINES_VH

// apb byte addresses, one aligned word each
`define FRM_ADDR_CTRL  8'h00
`define FRM_ADDR_STAT  8'h04
`define FRM_ADDR_DIAG  8'h08
`define FRM_ADDR_ISTAT 8'h0C
`define FRM_ADDR_IEN   8'h10
`define FRM_ADDR_ICLR  8'h14

// control register fields
`define FRM_CTRL_W   5
`define FRM_C_GO     0
`define FRM_C_SOF    1
`define FRM_C_RSC    2
`define FRM_C_DSR    3
`define FRM_C_WDM    4
`define FRM_CTRL_RST 5'h12

// interrupt status fields
`define FRM_IRQ_W    5
`define FRM_I_LATCH  0
`define FRM_I_SERIAL 1
`define FRM_I_TWARN  2
`define FRM_I_HRST   3
`define FRM_I_RSTRT  4
`define FRM_IEN_RST  5'h00

// widths of the read-only words
`define FRM_STAT_W   13
`define FRM_DIAG_W   18

// host reset hold time after the condition clears
`define FRM_HRST_MS  10
`define FRM_CLK_KHZ  50000

`endif

// *** src/frm_edge.v ***
// rise and fall detector for a bundle of level signals
`timescale 1ns/1ps
module frm_edge #(
    parameter WIDTH = 1
) (
    input wire clock_i,
    input wire rstn_i,
    input wire [WIDTH-1:0] sig_i,
    output wire [WIDTH-1:0] rise_o,
    output wire [WIDTH-1:0] fall_o
);
    reg [WIDTH-1:0] prev_r; // level seen one cycle ago

    // remember the previous level of every bit
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prev_r <= {WIDTH{1'b0}};
        end else begin
            prev_r <= sig_i;
        end
    end

    // combinational so the top sees the edge in the cycle it happens
    assign rise_o = sig_i & ~prev_r;
    assign fall_o = ~sig_i & prev_r;
endmodule // frm_edge

// *** src/frm_delay.v ***
// hold-off timer: pulses after a run level has stayed high for CYCLES clocks, and again every CYCLES clocks while it stays high
`timescale 1ns/1ps
module frm_delay #(
    parameter CYCLES = 500000,
    parameter CW = 20
) (
    input wire clock_i,
    input wire rstn_i,
    input wire run_i,
    output reg done_o
);
    localparam [31:0] LAST32 = CYCLES - 1; // terminal count
    wire [CW-1:0] last = LAST32[CW-1:0];
    reg [CW-1:0] cnt_r; // cycles spent with run high

    // counter restarts whenever run drops, so a glitch in the condition restarts the wait
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r <= {CW{1'b0}};
            done_o <= 1'b0;
        end else if (!run_i) begin
            cnt_r <= {CW{1'b0}};
            done_o <= 1'b0;
        end else if (cnt_r == last) begin
            cnt_r <= {CW{1'b0}};
            done_o <= 1'b1;
        end else begin
            cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
            done_o <= 1'b0;
        end
    end
endmodule // frm_delay

// *** src/frm_top.v ***
// fault response manager for a three-phase bridge gate driver, with apb registers
//
// How it works
// - full shutdown drives all six gates low
// - local shutdown drops only the affected gate
// - status/diag read clears latches when permitted
// - supply por disables, resets logic, no latch
// - sync loss with restart: stop, restart, no latch
// - restart off: latches clear on demand/go zero
// - logic-rail undervoltage latches, resets host 10 ms
// - overtemperature latches, regulator off, host reset
// - drain-source overvoltage latches, all gates off
// - latching responses only with stop-on-fault and watch masked
`timescale 1ns/1ps
`include "frm_defines.vh"
module frm_top #(
    parameter DW = 8,
    parameter HRST_CYCLES = `FRM_HRST_MS * `FRM_CLK_KHZ,
    parameter HRST_CW = 20
) (
    input wire clock_i,
    input wire rstn_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    input wire [DW-1:0] demand_i,
    input wire [5:0] gate_req_i,
    input wire sys_err_i,
    input wire serial_err_i,
    input wire vbb_por_i,
    input wire vbb_uv_i,
    input wire vlr_uv_i,
    input wire vreg_uv_i,
    input wire [5:0] boot_uv_i,
    input wire temp_warn_i,
    input wire overtemp_i,
    input wire sync_lost_i,
    input wire [5:0] vds_ov_i,
    output reg [5:0] gate_o,
    output reg host_reset_out_n_o,
    output reg logic_rail_regulator_en_o,
    output reg logic_reset_o,
    output reg restart_o,
    output reg irq_o
);
    ////////////////////////////////////////////////////////////////////////
    // declarations
    reg [`FRM_CTRL_W-1:0] ctrl_r; // go, stop-on-fault, restart, read-clear disable, watch mask
    reg [`FRM_IRQ_W-1:0] ist_r; // sticky interrupt status
    reg [`FRM_IRQ_W-1:0] ien_r; // interrupt enables
    reg sys_lat_r; // system error latched
    reg ser_lat_r; // serial error flag
    reg vbbuv_lat_r; // supply undervoltage latched
    reg boot_lat_r; // bootstrap undervoltage latched
    reg los_lat_r; // loss of sync latched
    reg vds_lat_r; // drain-source overvoltage latched
    reg vlr_lat_r; // logic-rail undervoltage latched
    reg ot_lat_r; // overtemperature latched
    reg [5:0] loc_r; // per-transistor local shutdown
    reg drive_en_r; // outputs enabled, for status
    reg [31:0] rdata_nxt; // read mux
    reg rerr_nxt; // unmapped address
    wire [`FRM_IRQ_W-1:0] ist_nxt;
    wire [`FRM_IRQ_W-1:0] ev;
    wire [1:0] lvl_rise;
    wire [1:0] lvl_fall;
    wire [5:0] pwm_on;
    wire hr_done;

    ////////////////////////////////////////////////////////////////////////
    // apb decode; a transfer completes at the edge where pready is seen high
    wire acc = psel_i & penable_i & pready_o;
    wire wr = acc & pwrite_i;
    wire rd = acc & ~pwrite_i;
    wire go = ctrl_r[`FRM_C_GO];
    wire restart_enable = ctrl_r[`FRM_C_RSC];
    // read of status or diag clears latches only while clearing is permitted
    wire rd_clr = rd & ~ctrl_r[`FRM_C_DSR] &
        ((paddr_i == `FRM_ADDR_STAT) | (paddr_i == `FRM_ADDR_DIAG));
    // the latching response set is gated by the two configuration bits; por and vreg are not
    wire resp_on = ctrl_r[`FRM_C_SOF] & ctrl_r[`FRM_C_WDM];
    wire dem_zero = (demand_i == {DW{1'b0}});
    // demand or go at zero resets the demand-path latches
    wire dr_clr = dem_zero | ~go | rd_clr;

    ////////////////////////////////////////////////////////////////////////
    // latch set terms, only while the responses are active
    wire sys_set = resp_on & sys_err_i;
    wire vbbuv_set = resp_on & ~restart_enable & vbb_uv_i;
    wire boot_set = resp_on & (|boot_uv_i);
    wire los_set = resp_on & ~restart_enable & sync_lost_i;
    wire vds_set = resp_on & (|vds_ov_i);
    wire vlr_set = resp_on & vlr_uv_i;
    wire ot_set = resp_on & overtemp_i;
    wire any_set = sys_set | vbbuv_set | boot_set | los_set | vds_set | vlr_set | ot_set;
    wire hr_lat = vlr_lat_r | ot_lat_r;

    ////////////////////////////////////////////////////////////////////////
    // edge detectors: go rising re-arms, sync loss falling restarts
    frm_edge #(.WIDTH(2)) u_lvl (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .sig_i({go, sync_lost_i}),
        .rise_o(lvl_rise),
        .fall_o(lvl_fall)
    );

    // per-transistor pwm on edge ends a local shutdown
    frm_edge #(.WIDTH(6)) u_pwm (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .sig_i(gate_req_i),
        .rise_o(pwm_on),
        .fall_o()
    );

    // host reset hold-off: counts only once both conditions have gone
    frm_delay #(.CYCLES(HRST_CYCLES), .CW(HRST_CW)) u_hrst (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .run_i(hr_lat & ~vlr_uv_i & ~overtemp_i),
        .done_o(hr_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // global shutdown: por and vreg always, the rest only with responses on
    wire glob_off = vbb_por_i | vreg_uv_i |
        (resp_on & (sys_lat_r | vbbuv_lat_r | boot_lat_r | los_lat_r | vds_lat_r | hr_lat |
        (restart_enable & (vbb_uv_i | sync_lost_i))));
    // demand-reset and go-reset sequences need no state: zero blocks drive, nonzero resumes
    wire drive_en = go & ~dem_zero & ~glob_off;

    ////////////////////////////////////////////////////////////////////////
    // fault latches; a set in the same cycle as a clear wins
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sys_lat_r <= 1'b0;
            ser_lat_r <= 1'b0;
            vbbuv_lat_r <= 1'b0;
            boot_lat_r <= 1'b0;
            los_lat_r <= 1'b0;
            vds_lat_r <= 1'b0;
            vlr_lat_r <= 1'b0;
            ot_lat_r <= 1'b0;
        end else if (vbb_por_i) begin
            // supply por resets the internal logic and never latches
            sys_lat_r <= 1'b0;
            ser_lat_r <= 1'b0;
            vbbuv_lat_r <= 1'b0;
            boot_lat_r <= 1'b0;
            los_lat_r <= 1'b0;
            vds_lat_r <= 1'b0;
            vlr_lat_r <= 1'b0;
            ot_lat_r <= 1'b0;
        end else begin
            // system error held until go is set again
            sys_lat_r <= sys_set | (sys_lat_r & ~lvl_rise[1]);
            // serial error is a flag only, it never touches the gates
            ser_lat_r <= serial_err_i | (ser_lat_r & ~rd_clr);
            vbbuv_lat_r <= vbbuv_set | (vbbuv_lat_r & ~dr_clr);
            boot_lat_r <= boot_set | (boot_lat_r & ~dr_clr);
            los_lat_r <= los_set | (los_lat_r & ~dr_clr);
            vds_lat_r <= vds_set | (vds_lat_r & ~dr_clr);
            // rail faults release only when the host reset hold-off expires
            vlr_lat_r <= vlr_set | (vlr_lat_r & ~hr_done);
            ot_lat_r <= ot_set | (ot_lat_r & ~hr_done);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // local shutdown, used while the stop-on-fault responses are off
    genvar k;
    generate
        for (k = 0; k < 6; k = k + 1) begin : g_loc
            // held until that transistor's pwm turns on again
            always @(posedge clock_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    loc_r[k] <= 1'b0;
                end else if (vbb_por_i) begin
                    loc_r[k] <= 1'b0;
                end else begin
                    loc_r[k] <= (~resp_on & (boot_uv_i[k] | vds_ov_i[k])) | (loc_r[k] & ~pwm_on[k]);
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // registered outputs toward the bridge and the host
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gate_o <= 6'h00;
            drive_en_r <= 1'b0;
            host_reset_out_n_o <= 1'b1;
            logic_rail_regulator_en_o <= 1'b1;
            logic_reset_o <= 1'b0;
            restart_o <= 1'b0;
        end else begin
            // all gates low on global shutdown, one gate low on local shutdown
            gate_o <= gate_req_i & {6{drive_en}} & ~loc_r;
            drive_en_r <= drive_en;
            host_reset_out_n_o <= ~hr_lat;
            logic_rail_regulator_en_o <= ~ot_lat_r;
            logic_reset_o <= vbb_por_i;
            // restart when the sync loss goes away, the stop itself is in glob_off
            restart_o <= resp_on & restart_enable & lvl_fall[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register; hardware clearing of go beats a software write
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_r <= `FRM_CTRL_RST;
            ien_r <= `FRM_IEN_RST;
        end else begin
            if (wr && (paddr_i == `FRM_ADDR_CTRL)) begin
                ctrl_r <= pwdata_i[`FRM_CTRL_W-1:0];
            end
            // go drops on system error or supply por, host must write it to 1 again
            if (sys_set || vbb_por_i) begin
                ctrl_r[`FRM_C_GO] <= 1'b0;
            end
            if (wr && (paddr_i == `FRM_ADDR_IEN)) begin
                ien_r <= pwdata_i[`FRM_IRQ_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts: sticky events, write-one-to-clear, set wins over clear
    assign ev[`FRM_I_LATCH] = any_set;
    assign ev[`FRM_I_SERIAL] = serial_err_i;
    assign ev[`FRM_I_TWARN] = temp_warn_i;
    assign ev[`FRM_I_HRST] = vlr_set | ot_set;
    assign ev[`FRM_I_RSTRT] = resp_on & restart_enable & lvl_fall[0];
    wire [`FRM_IRQ_W-1:0] iclr = (wr && (paddr_i == `FRM_ADDR_ICLR)) ?
        pwdata_i[`FRM_IRQ_W-1:0] : {`FRM_IRQ_W{1'b0}};
    assign ist_nxt = (ist_r & ~iclr) | ev;

    // the level output follows the next status so it is a flop, not a gate
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ist_r <= {`FRM_IRQ_W{1'b0}};
            irq_o <= 1'b0;
        end else begin
            ist_r <= ist_nxt;
            irq_o <= |(ist_nxt & ien_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux; live bits like temp warning clear themselves with the input
    always @* begin
        rdata_nxt = 32'h00000000;
        rerr_nxt = 1'b0;
        case (paddr_i)
            `FRM_ADDR_CTRL: begin
                rdata_nxt[`FRM_CTRL_W-1:0] = ctrl_r;
            end
            `FRM_ADDR_STAT: begin
                rdata_nxt[`FRM_STAT_W-1:0] = {drive_en_r, ~host_reset_out_n_o, vds_lat_r, los_lat_r,
                    ot_lat_r, temp_warn_i, boot_lat_r, vreg_uv_i, vlr_lat_r, vbbuv_lat_r,
                    vbb_por_i, ser_lat_r, sys_lat_r};
            end
            `FRM_ADDR_DIAG: begin
                rdata_nxt[`FRM_DIAG_W-1:0] = {loc_r, vds_ov_i, boot_uv_i};
            end
            `FRM_ADDR_ISTAT: begin
                rdata_nxt[`FRM_IRQ_W-1:0] = ist_r;
            end
            `FRM_ADDR_IEN: begin
                rdata_nxt[`FRM_IRQ_W-1:0] = ien_r;
            end
            `FRM_ADDR_ICLR: begin
                rdata_nxt = 32'h00000000; // write-only, reads zero
            end
            default: begin
                rerr_nxt = 1'b1; // unmapped address answers with an error
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // apb answer: one wait state, data captured before any read clear lands
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h00000000;
        end else if (psel_i && penable_i && !pready_o) begin
            pready_o <= 1'b1;
            pslverr_o <= rerr_nxt;
            prdata_o <= pwrite_i ? 32'h00000000 : rdata_nxt;
        end else begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end
    end
endmodule // frm_top

// *** testbench/frm_host.sv ***
// host model: apb master and demand source facing the fault response manager
`timescale 1ns/1ps
`include "frm_defines.vh"
module frm_host (
    input wire clock_i,
    input wire pready_i,
    input wire pslverr_i,
    input wire [31:0] prdata_i,
    output logic psel_o = 1'b0,
    output logic penable_o = 1'b0,
    output logic pwrite_o = 1'b0,
    output logic [7:0] paddr_o = 8'h00,
    output logic [31:0] pwdata_o = 32'h0,
    output logic [7:0] demand_o = 8'h05
);
    // one transfer; the request stands until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge clock_i);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clock_i);
        penable_o <= 1'b1;
        do @(posedge clock_i); while (pready_i !== 1'b1);
        q = prdata_i;
        e = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
    endtask
    // demand to zero first, then a fresh operating value
    task automatic demand_reset(input logic [7:0] v);
        @(posedge clock_i);
        demand_o <= 8'h00;
        repeat (3) @(posedge clock_i);
        demand_o <= v;
    endtask
    // go written low, then high; other control bits kept
    task automatic go_toggle(input logic [31:0] c);
        logic [31:0] q;
        logic e;
        apb(1'b1, `FRM_ADDR_CTRL, c & 32'hFFFFFFFE, q, e);
        apb(1'b1, `FRM_ADDR_CTRL, c | 32'h1, q, e);
    endtask
endmodule // frm_host

// *** testbench/frm_checker.sv ***
// port-level assertions for the fault response manager
`timescale 1ns/1ps
`include "frm_defines.vh"
module frm_checker #(
    parameter HRST_CYCLES = 20
) (
    input wire clock_i,
    input wire rstn_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire pready_o,
    input wire pslverr_o,
    input wire [5:0] gate_req_i,
    input wire vbb_por_i,
    input wire vlr_uv_i,
    input wire vreg_uv_i,
    input wire overtemp_i,
    input wire sync_lost_i,
    input wire [5:0] vds_ov_i,
    input wire [5:0] gate_o,
    input wire host_reset_out_n_o,
    input wire logic_rail_regulator_en_o,
    input wire logic_reset_o,
    input wire restart_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    reg [4:0] ctrl_r; // shadow of the control word, seen from the bus
    reg [31:0] quiet_r; // cycles since both host reset causes went away
    wire resp = ctrl_r[`FRM_C_SOF] & ctrl_r[`FRM_C_WDM];
    ////////////////////////////////////////
    // shadow follows completed writes only, so its stop-on-fault and watch mask bits match the design; hardware clearing of go is not mirrored
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_r <= `FRM_CTRL_RST;
            quiet_r <= 32'h0;
        end else begin
            if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == `FRM_ADDR_CTRL) begin
                ctrl_r <= pwdata_i[4:0];
            end
            quiet_r <= (vlr_uv_i || overtemp_i) ? 32'h0 : quiet_r + 32'h1;
        end
    end
    ////////////////////////////////////////
    property p_por; vbb_por_i |=> logic_reset_o && gate_o == 6'h00; endproperty
    a_por: assert property (p_por) else $error("supply reset left gates or logic running");
    property p_vreg; vreg_uv_i |=> gate_o == 6'h00; endproperty
    a_vreg: assert property (p_vreg) else $error("gates on during regulator undervoltage");
    property p_mask; (gate_o & ~$past(gate_req_i)) == 6'h00; endproperty
    a_mask: assert property (p_mask) else $error("gate driven without request");
    property p_vds; resp && vds_ov_i != 6'h00 |-> ##2 gate_o == 6'h00; endproperty
    a_vds: assert property (p_vds) else $error("overvoltage did not stop all gates");
    property p_vlr; resp && vlr_uv_i |-> ##[1:3] !host_reset_out_n_o; endproperty
    a_vlr: assert property (p_vlr) else $error("host reset not asserted on rail undervoltage");
    property p_ot; resp && overtemp_i |-> ##[1:3] !logic_rail_regulator_en_o && !host_reset_out_n_o; endproperty
    a_ot: assert property (p_ot) else $error("overtemperature left regulator or host running");
    property p_hold; $rose(host_reset_out_n_o) |-> quiet_r >= HRST_CYCLES; endproperty
    a_hold: assert property (p_hold) else $error("host reset released early");
    property p_late; quiet_r == HRST_CYCLES + 4 |-> host_reset_out_n_o; endproperty
    a_late: assert property (p_late) else $error("host reset held too long");
    property p_rst;
        restart_o |-> !sync_lost_i && ($past(sync_lost_i, 2) || $past(sync_lost_i, 3));
    endproperty
    a_rst: assert property (p_rst) else $error("restart without sync loss ending");
    property p_rdy; psel_i && penable_i && !pready_o |=> pready_o; endproperty
    a_rdy: assert property (p_rdy) else $error("bus answer late");
    property p_err; pslverr_o |-> pready_o && paddr_i > `FRM_ADDR_ICLR; endproperty
    a_err: assert property (p_err) else $error("error answer on mapped address");
    c_vds: cover property (resp && vds_ov_i != 6'h00);
    c_hrst: cover property ($rose(host_reset_out_n_o));
    c_rst: cover property (restart_o);
endmodule // frm_checker
bind frm_top frm_checker #(.HRST_CYCLES(HRST_CYCLES)) u_chk (.clock_i, .rstn_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .gate_req_i, .vbb_por_i, .vlr_uv_i,
    .vreg_uv_i, .overtemp_i, .sync_lost_i, .vds_ov_i, .gate_o, .host_reset_out_n_o,
    .logic_rail_regulator_en_o, .logic_reset_o, .restart_o);

// *** testbench/tb_top.sv ***
// self-checking bench for the fault response manager
`timescale 1ns/1ps
`include "frm_defines.vh"
module tb_top;
    reg clock_i = 1'b0;
    reg rstn_i = 1'b0;
    reg [5:0] gate_req_i = 6'h3F, boot_uv_i = 6'h00, vds_ov_i = 6'h00;
    reg sys_err_i = 1'b0, serial_err_i = 1'b0, vbb_por_i = 1'b0, vbb_uv_i = 1'b0, vlr_uv_i = 1'b0;
    reg vreg_uv_i = 1'b0, temp_warn_i = 1'b0, overtemp_i = 1'b0, sync_lost_i = 1'b0;
    wire psel_i, penable_i, pwrite_i, pready_o, pslverr_o, host_reset_out_n_o, irq_o;
    wire logic_rail_regulator_en_o, logic_reset_o, restart_o;
    wire [7:0] paddr_i, demand_i;
    wire [31:0] pwdata_i, prdata_o;
    wire [5:0] gate_o;
    int n_fail = 0;
    int checks_done = 0;
    logic [31:0] q;
    logic e;
    always #10 clock_i = ~clock_i;
    frm_host u_host (.clock_i(clock_i), .pready_i(pready_o), .pslverr_i(pslverr_o), .prdata_i(prdata_o),
        .psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i),
        .pwdata_o(pwdata_i), .demand_o(demand_i));
    frm_top #(.HRST_CYCLES(20)) DUT (.clock_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .demand_i, .gate_req_i, .sys_err_i, .serial_err_i,
        .vbb_por_i, .vbb_uv_i, .vlr_uv_i, .vreg_uv_i, .boot_uv_i, .temp_warn_i, .overtemp_i,
        .sync_lost_i, .vds_ov_i, .gate_o, .host_reset_out_n_o, .logic_rail_regulator_en_o,
        .logic_reset_o, .restart_o, .irq_o);
    ////////////////////////////////////////
    task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask
    task cyc(input int k);
        repeat (k) @(posedge clock_i);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        u_host.apb(1'b1, a, d, q, e);
    endtask
    task rd(input logic [7:0] a);
        u_host.apb(1'b0, a, 32'h0, q, e);
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////
    // reset state, run enable and a refused address
    task t_start;
        rd(`FRM_ADDR_CTRL);
        chk("ctrl", q, 32'h12);
        chk("hrst", host_reset_out_n_o, 1'b1);
        wr(`FRM_ADDR_CTRL, 32'h13);
        cyc(3);
        chk("run", gate_o, 6'h3F);
        rd(8'h40);
        chk("slverr", e, 1'b1);
        chk("slvq", q, 32'h00000000);
    endtask
    // latched overvoltage; a read clears it only with read-clear allowed
    task t_vds;
        vds_ov_i <= 6'h01;
        cyc(3);
        vds_ov_i <= 6'h00;
        chk("vds", gate_o, 6'h00);
        cyc(3);
        chk("vdsl", gate_o, 6'h00);
        wr(`FRM_ADDR_CTRL, 32'h1B);
        rd(`FRM_ADDR_STAT);
        cyc(3);
        chk("dsr", gate_o, 6'h00);
        wr(`FRM_ADDR_CTRL, 32'h13);
        rd(`FRM_ADDR_DIAG);
        cyc(3);
        chk("rdclr", gate_o, 6'h3F);
    endtask
    // bootstrap latch cleared by demand, undervoltage latch by go
    task t_latch;
        boot_uv_i <= 6'h04;
        cyc(3);
        boot_uv_i <= 6'h00;
        cyc(3);
        chk("boot", gate_o, 6'h00);
        u_host.demand_reset(8'h05);
        cyc(3);
        chk("dem", gate_o, 6'h3F);
        vbb_uv_i <= 1'b1;
        cyc(3);
        vbb_uv_i <= 1'b0;
        cyc(3);
        chk("vbbuv", gate_o, 6'h00);
        u_host.go_toggle(32'h13);
        cyc(3);
        chk("go", gate_o, 6'h3F);
    endtask
    // host reset causes; hold counted after the cause goes away
    task t_hrst(input int ot);
        vlr_uv_i <= (ot == 0);
        overtemp_i <= (ot != 0);
        cyc(4);
        chk("hlow", {host_reset_out_n_o, gate_o}, 7'h00);
        chk("vlr", logic_rail_regulator_en_o, (ot == 0));
        vlr_uv_i <= 1'b0;
        overtemp_i <= 1'b0;
        cyc(12);
        chk("hold", host_reset_out_n_o, 1'b0);
        cyc(20);
        chk("hrel", host_reset_out_n_o, 1'b1);
        u_host.go_toggle(32'h13);
        cyc(3);
        chk("hgo", gate_o, 6'h3F);
    endtask
    // sync loss with restart on: stop, one restart pulse, no latch
    task t_sync;
        int seen;
        seen = 0;
        wr(`FRM_ADDR_CTRL, 32'h17);
        sync_lost_i <= 1'b1;
        cyc(3);
        chk("sstop", gate_o, 6'h00);
        sync_lost_i <= 1'b0;
        repeat (8) begin
            @(posedge clock_i);
            if (restart_o === 1'b1) seen++;
        end
        chk("rpulse", seen, 1);
        chk("srun", gate_o, 6'h3F);
        wr(`FRM_ADDR_CTRL, 32'h13);
    endtask
    // regulator dip while running, then supply reset stops everything and clears go
    task t_por;
        vreg_uv_i <= 1'b1;
        cyc(2);
        chk("vreg", gate_o, 6'h00);
        vreg_uv_i <= 1'b0;
        vbb_por_i <= 1'b1;
        cyc(2);
        chk("por", {logic_reset_o, gate_o}, 7'h40);
        vbb_por_i <= 1'b0;
        rd(`FRM_ADDR_CTRL);
        chk("pgo", q[0], 1'b0);
        wr(`FRM_ADDR_CTRL, 32'h13);
        cyc(3);
        chk("prun", gate_o, 6'h3F);
        // system error stops the gates and drops go until go is written again
        sys_err_i <= 1'b1;
        cyc(1);
        sys_err_i <= 1'b0;
        cyc(3);
        chk("sys", gate_o, 6'h00);
        wr(`FRM_ADDR_CTRL, 32'h13);
        cyc(3);
        chk("sgo", gate_o, 6'h3F);
    endtask
    // serial error and temperature warning report without shutdown
    task t_warn;
        serial_err_i <= 1'b1;
        temp_warn_i <= 1'b1;
        cyc(1);
        serial_err_i <= 1'b0;
        cyc(3);
        chk("wrun", gate_o, 6'h3F);
        rd(`FRM_ADDR_STAT);
        chk("wst", {q[7], q[1]}, 2'h3);
        temp_warn_i <= 1'b0;
        rd(`FRM_ADDR_STAT);
        chk("wclr", {q[7], q[1]}, 2'h0);
    endtask
    // responses off: only the faulty gate drops until it is requested afresh
    task t_off;
        wr(`FRM_ADDR_CTRL, 32'h11);
        vds_ov_i <= 6'h01;
        vbb_uv_i <= 1'b1;
        cyc(3);
        chk("loc", gate_o, 6'h3E);
        vds_ov_i <= 6'h00;
        vbb_uv_i <= 1'b0;
        cyc(3);
        chk("lock", gate_o, 6'h3E);
        gate_req_i <= 6'h3E;
        cyc(2);
        gate_req_i <= 6'h3F;
        cyc(3);
        chk("lrel", gate_o, 6'h3F);
        wr(`FRM_ADDR_CTRL, 32'h13);
    endtask
    // interrupt raised, cleared and masked
    task t_irq;
        wr(`FRM_ADDR_ICLR, 32'h1F);
        wr(`FRM_ADDR_IEN, 32'h01);
        vds_ov_i <= 6'h02;
        cyc(3);
        vds_ov_i <= 6'h00;
        cyc(2);
        chk("irq", irq_o, 1'b1);
        rd(`FRM_ADDR_STAT);
        wr(`FRM_ADDR_ICLR, 32'h01);
        cyc(2);
        chk("iclr", irq_o, 1'b0);
        serial_err_i <= 1'b1;
        cyc(1);
        serial_err_i <= 1'b0;
        cyc(2);
        chk("imask", irq_o, 1'b0);
        wr(`FRM_ADDR_IEN, 32'h02);
        cyc(2);
        chk("ien", irq_o, 1'b1);
        wr(8'h40, 32'h1F);
        chk("werr", e, 1'b1);
    endtask
    ////////////////////////////////////////
    initial begin
        cyc(20);
        rstn_i <= 1'b1;
        t_start;
        t_vds;
        t_latch;
        t_hrst(0);
        t_hrst(1);
        t_sync;
        t_por;
        t_warn;
        t_off;
        t_irq;
        tally_and_finish;
    end
    // watchdog well beyond the few hundred cycles the scenarios need
    initial begin
        cyc(20000);
        n_fail++;
        tally_and_finish;
    end
endmodule // tb_top
